/* bcor_edge.sv */
// Rising-edge detector for an input strobe sampled on the system clock.
// Assumes the input is already synchronous to mclk_i.
`timescale 1ns/1ps
module bcor_edge (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic srst_i,
   // Strobe
   input  wire logic lvl_i,
   output logic      rise_o
);
   typedef struct packed {
      logic prev;
   } bcor_edge_st_t;

   bcor_edge_st_t st_q;
   bcor_edge_st_t st_d;

   always_comb begin
      st_d      = st_q;
      st_d.prev = lvl_i;
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rise_o = lvl_i & ~st_q.prev;
endmodule : bcor_edge

/* bcor_far.sv */
// Far-side logic that reads the parallel output pins of the counter.
// Assumes q_oe_i bits are high while the device drives the matching pin.
`timescale 1ns/1ps
module bcor_far (
   // Clock
   input  wire logic       mclk_i,
   // Device pins
   input  wire logic [7:0] q_i,
   input  wire logic [7:0] q_oe_i,
   // Resolved pin levels
   output logic [7:0]      pin_o
);
   logic [7:0] float_q = 8'h00;

   // A released pin has no pull, so it shows a pattern that changes every cycle.
   always @(posedge mclk_i) begin
      float_q <= ~float_q;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_o[i] = q_oe_i[i] ? q_i[i] : float_q[i];
      end
   end
endmodule : bcor_far

/* bcor_pkg.sv */
// Package for the binary counter with output register.
// Assumes a single 100 MHz system clock and synchronous inputs.
package bcor_pkg;

   // ---------------------------------------------------------------
   // Widths and values
   // ---------------------------------------------------------------
   localparam int unsigned CNT_W    = 8;
   localparam logic [7:0]  CNT_ZERO = 8'h00;
   localparam logic [7:0]  CNT_ONE  = 8'h01;
   localparam logic [7:0]  CNT_MAX  = 8'hFF;
   localparam logic [7:0]  REG_RST  = 8'h00;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       counter_clock;
      logic       rclk;
      logic       clear_n;
      logic       cen_n;
      logic       oe_n;
   } bcor_ctl_t;

   typedef struct packed {
      logic [7:0] q;
      logic [7:0] q_oe;
      logic       carry_n;
   } bcor_out_t;

endpackage : bcor_pkg

/* bcor_top.sv */
// Contract
// [RULE1] Eight-bit up-counter feeds eight-bit storage register.
// [RULE2] Counter and register use separate clock strobes.
// [RULE3] Advance and load only on rising edges.
// [RULE4] Clear low zeroes counter at once.
// [RULE5] Count only while count enable is low.
// [RULE6] Enable change alone never increments the count.
// [RULE7] Register captures count from before same edge.
// [RULE8] First count after clear is one.
// [RULE9] Outputs tristate; register contents kept meanwhile.
// [RULE10] Counter keeps counting while outputs disabled.
// [RULE11] Register edge loads current count value.
// [RULE12] Counter rolls from maximum to zero.
// [RULE13] Ripple carry output provided for cascading.
// [RULE14] Longer chains route carry to next clock.
// [RULE15] Carry low at max count with enable.
// [RULE16] Output enable active low; high means tristate.
//
// Top of the binary counter with output register.
// The device clocks are strobes sampled on mclk_i; edges are detected here.
`timescale 1ns/1ps
module bcor_top (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       srst_i,
   // Control pins
   input  wire logic       counter_clock_i,
   input  wire logic       register_clock_i,
   input  wire logic       counter_clear_n_i,
   input  wire logic       count_enable_n_i,
   input  wire logic       output_enable_n_i,
   // Parallel outputs and carry
   output logic [7:0]      q_o,
   output logic [7:0]      q_oe_o,
   output logic            carry_out_n_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] store;
      logic [7:0] q;
      logic [7:0] q_oe;
      logic       carry_n;
   } bcor_st_t;

   bcor_st_t st_q;
   bcor_st_t st_d;
   logic     counter_clock_rise;
   logic     rclk_rise;
   logic [7:0] count_next;

   function automatic logic [7:0] bcor_inc(input logic [7:0] v);
      bcor_inc = v + 8'h01;
   endfunction : bcor_inc

   // ---------------------------------------------------------------
   // Edge detection
   // ---------------------------------------------------------------
   // Each clock strobe has its own detector so neither stage sees the other.
   bcor_edge u_counter_clock_edge ( // RULE2
      .mclk_i (mclk_i),
      .srst_i (srst_i),
      .lvl_i  (counter_clock_i),
      .rise_o (counter_clock_rise)
   );

   bcor_edge u_rclk_edge (
      .mclk_i (mclk_i),
      .srst_i (srst_i),
      .lvl_i  (register_clock_i),
      .rise_o (rclk_rise)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d       = st_q;
      count_next = st_q.count;
      // Only a counter clock edge may advance; the enable is a qualifier.
      if (counter_clock_rise && !count_enable_n_i) begin // RULE3 RULE5 RULE6
         count_next = bcor_inc(st_q.count); // RULE1 RULE12
      end
      // Clear dominates any edge in the same cycle and holds while low.
      if (!counter_clear_n_i) begin // RULE4 RULE8
         count_next = bcor_pkg::CNT_ZERO;
      end
      st_d.count = count_next; // RULE10
      // The register takes the old count, so tied clocks lag by one.
      if (rclk_rise) begin // RULE7 RULE11
         st_d.store = st_q.count;
      end
      // Drivers follow the stored value; disabling leaves the store alone.
      st_d.q    = st_d.store; // RULE9
      st_d.q_oe = output_enable_n_i ? 8'h00 : 8'hFF; // RULE16
      // Carry is a level on the next count and enable, so it never lags.
      st_d.carry_n = !((count_next == bcor_pkg::CNT_MAX) && !count_enable_n_i
                       && counter_clear_n_i); // RULE13 RULE15
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // No power-on reset exists in the part; srst_i gives a known start.
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         st_q.count   <= bcor_pkg::CNT_ZERO;
         st_q.store   <= bcor_pkg::REG_RST;
         st_q.q       <= bcor_pkg::REG_RST;
         st_q.q_oe    <= 8'h00;
         st_q.carry_n <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign q_o           = st_q.q;
   assign q_oe_o        = st_q.q_oe;
   assign carry_out_n_o = st_q.carry_n;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_clear_zero: assert property (@(posedge mclk_i) disable iff (srst_i) // RULE4
      !srst_i && !counter_clear_n_i |=> st_q.count == 8'h00)
      else $error("count not zero after clear");

   chk_count_step: assert property (@(posedge mclk_i) disable iff (srst_i) // RULE5
      (!srst_i && counter_clock_rise && !count_enable_n_i && counter_clear_n_i)
      |=> st_q.count == $past(st_q.count) + 8'h01)
      else $error("count did not advance");

   chk_count_hold: assert property (@(posedge mclk_i) disable iff (srst_i) // RULE6
      !srst_i && (!counter_clock_rise || count_enable_n_i) && counter_clear_n_i
      |=> st_q.count == $past(st_q.count))
      else $error("count changed without an enabled edge");

   chk_store_old: assert property (@(posedge mclk_i) disable iff (srst_i) // RULE7
      !srst_i && rclk_rise |=> st_q.store == $past(st_q.count))
      else $error("register did not take the prior count");

   chk_store_hold: assert property (@(posedge mclk_i) disable iff (srst_i) // RULE9
      !srst_i && !rclk_rise |=> st_q.store == $past(st_q.store))
      else $error("register changed without its edge");

   chk_out_data: assert property (@(posedge mclk_i) disable iff (srst_i) // RULE11
      !srst_i && rclk_rise |=> ##1 q_o == $past(st_q.count, 2))
      else $error("outputs do not show loaded count");

   chk_oe_level: assert property (@(posedge mclk_i) disable iff (srst_i) // RULE16
      !srst_i |=> q_oe_o == ($past(output_enable_n_i) ? 8'h00 : 8'hFF))
      else $error("output enable wrong");

   chk_roll_over: assert property (@(posedge mclk_i) disable iff (srst_i) // RULE12
      (!srst_i && st_q.count == 8'hFF && counter_clock_rise && !count_enable_n_i
       && counter_clear_n_i)
      |=> st_q.count == 8'h00)
      else $error("counter did not roll over");

   chk_carry_max: assert property (@(posedge mclk_i) disable iff (srst_i) // RULE15
      !srst_i |=> carry_out_n_o == !(st_q.count == 8'hFF && $past(!count_enable_n_i)
                             && $past(counter_clear_n_i)))
      else $error("carry out wrong");

   cov_first_count: cover property (@(posedge mclk_i) disable iff (srst_i)
      !counter_clear_n_i ##1 (counter_clock_rise && !count_enable_n_i) ##1 st_q.count == 8'h01);
   cov_tied_clocks: cover property (@(posedge mclk_i) disable iff (srst_i)
      counter_clock_rise && rclk_rise && !count_enable_n_i);
   cov_roll: cover property (@(posedge mclk_i) disable iff (srst_i)
      st_q.count == 8'hFF ##1 st_q.count == 8'h00);
   cov_carry: cover property (@(posedge mclk_i) disable iff (srst_i) !carry_out_n_o);

endmodule : bcor_top

/* test_binary_counter_with_output_register.sv */
// Self-checking bench for the counter with output register.
// Assumes bcor_top and bcor_far are compiled before it.
`timescale 1ns/1ps
module test_binary_counter_with_output_register;
   logic       mclk_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       counter_clock   = 1'b0;
   logic       rclk   = 1'b0;
   logic       clr_n  = 1'b1;
   logic       cen_n  = 1'b0;
   logic       oe_n   = 1'b0;
   logic [7:0] q;
   logic [7:0] q_oe;
   logic [7:0] pin;
   logic       carry_n;
   int         err_total = 0;
   int         total_checks = 0;
   int         cyc = 0;
   int         cnt = 0, st = 0, qm = 0, oem = 0, carm = 1, cp = 0, rp = 0;

   bcor_top dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .counter_clock_i(counter_clock),
      .register_clock_i(rclk), .counter_clear_n_i(clr_n), .count_enable_n_i(cen_n),
      .output_enable_n_i(oe_n), .q_o(q), .q_oe_o(q_oe), .carry_out_n_o(carry_n));
   bcor_far far_u (.mclk_i(mclk_i), .q_i(q), .q_oe_i(q_oe), .pin_o(pin));

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop;
      if (err_total == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   // Each strobe edge takes two cycles: low for one edge, then high.
   task automatic step(input logic c, input logic r, input logic en_n);
      @(posedge mclk_i);
      counter_clock  <= 1'b0;
      rclk  <= 1'b0;
      cen_n <= en_n;
      @(posedge mclk_i);
      counter_clock <= c;
      rclk <= r;
   endtask : step

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         report_and_stop;
      end
      if (srst_i) begin
         cnt = 0;
         st  = 0;
         qm  = 0;
         oem = 0;
         carm = 1;
      end else begin
         if (rclk && !rp) st = cnt;
         qm = st;
         if (!clr_n) cnt = 0;
         else if (counter_clock && !cp && !cen_n) cnt = (cnt + 1) % 256;
         oem  = oe_n ? 0 : 255;
         carm = (cnt == 255 && !cen_n && clr_n) ? 0 : 1;
      end
      cp = srst_i ? 0 : int'(counter_clock);
      rp = srst_i ? 0 : int'(rclk);
   end

   always @(negedge mclk_i) begin
      check(q, 8'(qm));
      check(q_oe, 8'(oem));
      check({7'h00, carry_n}, 8'(carm));
      if (oem != 0) check(pin, 8'(qm));
   end

   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(39205));
      repeat (16) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      clr_n <= 1'b0;
      @(posedge mclk_i);
      clr_n <= 1'b1;
      step(1'b1, 1'b1, 1'b0);
      step(1'b1, 1'b1, 1'b1);
      repeat (3) @(posedge mclk_i) cen_n <= ~cen_n;
      step(1'b1, 1'b0, 1'b0);
      step(1'b1, 1'b0, 1'b0);
      oe_n <= 1'b1;
      step(1'b1, 1'b0, 1'b0);
      step(1'b0, 1'b1, 1'b0);
      oe_n <= 1'b0;
      step(1'b1, 1'b0, 1'b0);
      step(1'b0, 1'b1, 1'b0);
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      check(q, 8'h05);
      repeat (260) step(1'b1, 1'($urandom % 2), 1'b0);
      repeat (400) begin
         clr_n <= ($urandom % 32) != 0;
         oe_n  <= 1'($urandom % 2);
         step(($urandom % 4) != 0, 1'($urandom % 2), ($urandom % 8) == 0);
      end
      srst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      srst_i <= 1'b0;
      repeat (20) step(1'b1, 1'b1, 1'b0);
      report_and_stop;
   end
endmodule : test_binary_counter_with_output_register
